// file: pmwg_map.vh
// Purpose: constants for the program memory write guard
// Assumes: word-addressed program memory, 512-word pages
// Notes:   register offsets are byte addresses on APB
`ifndef PMWG_MAP_VH
`define PMWG_MAP_VH

// ----------------------------------------
// address geometry
// ----------------------------------------
`define PMWG_ADDR_W        17
`define PMWG_PAGE_SHIFT    9
`define PMWG_PAGE_W        8
`define PMWG_LAST_PAGE     8'hFF

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PMWG_OFS_CTRL      12'h000
`define PMWG_OFS_STAT      12'h004
`define PMWG_OFS_CFG       12'h008

// ----------------------------------------
// config word fields
// ----------------------------------------
`define PMWG_CFG_W         13
`define PMWG_CFG_EAP       0
`define PMWG_CFG_GWP       1
`define PMWG_CFG_DIS       2
`define PMWG_CFG_END       3
`define PMWG_CFG_LPP       4
`define PMWG_CFG_PG_LO     5
`define PMWG_CFG_PG_HI     12
`define PMWG_CFG_RESET     13'h1FFF

// ----------------------------------------
// status fields
// ----------------------------------------
`define PMWG_ST_DONE       0
`define PMWG_ST_REJ        1
`define PMWG_ST_PERR       2
`define PMWG_ST_LOADED     3

// ----------------------------------------
// request kinds
// ----------------------------------------
`define PMWG_OP_READ       2'h0
`define PMWG_OP_WRITE      2'h1
`define PMWG_OP_ERASE      2'h2

`endif

// file: pmwg_shadow.v
// Purpose: configuration register held with a complement shadow
// Assumes: load is a one-cycle strobe
// Notes:   mismatch is checked every cycle
`timescale 1ns/1ps
`include "pmwg_map.vh"

module pmwg_shadow (
   pclk,
   presetn,
   load,
   din,
   flip,
   value,
   mismatch
);
   input  wire                     pclk;
   input  wire                     presetn;
   input  wire                     load;
   input  wire [`PMWG_CFG_W-1:0]   din;
   input  wire [`PMWG_CFG_W-1:0]   flip;
   output wire [`PMWG_CFG_W-1:0]   value;
   output reg                      mismatch;

   reg [`PMWG_CFG_W-1:0] actual;
   reg [`PMWG_CFG_W-1:0] shadow;

   assign value = actual;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         actual   <= `PMWG_CFG_RESET;
         shadow   <= ~`PMWG_CFG_RESET;
         mismatch <= 1'b0;
      end else begin
         if (load) begin
            actual <= din;
            shadow <= ~din;
         end else begin
            // flip models a disturbed cell on the live copy
            actual <= actual ^ flip;
         end
         mismatch <= ((actual ^ shadow) != {`PMWG_CFG_W{1'b1}});
      end
   end
endmodule // pmwg_shadow

// file: pmwg_guard.v
// Purpose: decides whether program memory access is allowed
// Assumes: config word presented once after reset via cfg_valid
// Notes:   APB holds a status clear control word plus status and config readback
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`include "pmwg_map.vh"

module pmwg_guard (
   pclk,
   presetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   cfg_word,
   cfg_valid,
   cfg_flip,
   req_valid,
   req_op,
   req_addr,
   req_external,
   grant_valid,
   grant_ok,
   grant_op,
   grant_addr,
   parity_error,
   device_reset
);
   input  wire                     pclk;
   input  wire                     presetn;
   input  wire                     psel;
   input  wire                     penable;
   input  wire                     pwrite;
   input  wire [11:0]              paddr;
   input  wire [31:0]              pwdata;
   output reg  [31:0]              prdata;
   output reg                      pready;
   output reg                      pslverr;
   input  wire [`PMWG_CFG_W-1:0]   cfg_word;
   input  wire                     cfg_valid;
   input  wire [`PMWG_CFG_W-1:0]   cfg_flip;
   input  wire                     req_valid;
   input  wire [1:0]               req_op;
   input  wire [`PMWG_ADDR_W-1:0]  req_addr;
   input  wire                     req_external;
   output reg                      grant_valid;
   output reg                      grant_ok;
   output reg  [1:0]               grant_op;
   output reg  [`PMWG_ADDR_W-1:0]  grant_addr;
   output reg                      parity_error;
   output reg                      device_reset;

   // ----------------------------------------
   // configuration capture
   // ----------------------------------------
   reg                         loaded;
   wire                        cfg_load;
   wire [`PMWG_CFG_W-1:0]      cfg;
   wire                        cfg_bad;

   assign cfg_load = cfg_valid & ~loaded;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded <= 1'b0;
      end else if (cfg_valid) begin
         loaded <= 1'b1;
      end
   end

   pmwg_shadow u_shadow (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (cfg_load),
      .din      (cfg_word),
      .flip     (cfg_flip),
      .value    (cfg),
      .mismatch (cfg_bad)
   );

   // ----------------------------------------
   // configuration fields
   // ----------------------------------------
   wire                          ext_protect;
   wire                          wr_enable;
   wire                          seg_off;
   wire                          seg_top;
   wire                          last_open;
   wire [`PMWG_PAGE_W-1:0]       bound_page;

   // protect bits are active low, as programmed cells read 0
   assign ext_protect = ~cfg[`PMWG_CFG_EAP];
   assign wr_enable   = cfg[`PMWG_CFG_GWP];
   assign seg_off     = cfg[`PMWG_CFG_DIS];
   assign seg_top     = cfg[`PMWG_CFG_END];
   assign last_open   = cfg[`PMWG_CFG_LPP];
   assign bound_page  = cfg[`PMWG_CFG_PG_HI:`PMWG_CFG_PG_LO];

   // ----------------------------------------
   // request decode
   // ----------------------------------------
   wire                          is_read;
   wire                          is_write;
   wire                          is_erase;
   wire                          is_bad;
   wire                          is_mod;
   wire [`PMWG_PAGE_W-1:0]       page;

   // an unknown op code is refused outright
   assign is_read  = (req_op == `PMWG_OP_READ);
   assign is_write = (req_op == `PMWG_OP_WRITE);
   assign is_erase = (req_op == `PMWG_OP_ERASE);
   assign is_bad   = ~(is_read | is_write | is_erase);
   assign is_mod   = is_write | is_erase;
   // whole array is one general segment, so only the page number matters
   assign page     = req_addr[`PMWG_ADDR_W-1:`PMWG_PAGE_SHIFT];

   // ----------------------------------------
   // segment range
   // ----------------------------------------
   reg  [`PMWG_PAGE_W-1:0]       seg_lo;
   reg  [`PMWG_PAGE_W-1:0]       seg_hi;
   wire [`PMWG_ADDR_W-1:0]       seg_lo_addr;
   wire [`PMWG_ADDR_W-1:0]       seg_hi_addr;
   reg                           in_range;
   reg                           cfg_page_hit;
   reg                           seg_hit;

   // the boundary page is inside the range at either end
   always @* begin
      if (seg_top) begin
         seg_lo = bound_page;
         seg_hi = `PMWG_LAST_PAGE;
      end else begin
         seg_lo = {`PMWG_PAGE_W{1'b0}};
         seg_hi = bound_page;
      end
   end

   // first word of the low page and last word of the high page
   assign seg_lo_addr = {seg_lo, {`PMWG_PAGE_SHIFT{1'b0}}};
   assign seg_hi_addr = {seg_hi, {`PMWG_PAGE_SHIFT{1'b1}}};

   // the last page guard only applies with the range anchored at the bottom
   always @* begin
      in_range     = (req_addr >= seg_lo_addr) && (req_addr <= seg_hi_addr);
      cfg_page_hit = 1'b0;
      if (!seg_top && !last_open && page == `PMWG_LAST_PAGE) begin
         cfg_page_hit = 1'b1;
      end
      seg_hit = 1'b0;
      if (!seg_off) begin
         seg_hit = in_range | cfg_page_hit;
      end
   end

   // ----------------------------------------
   // global protection and decision
   // ----------------------------------------
   wire                          glob_ext_deny;
   wire                          glob_int_deny;
   reg                           deny;

   // write protect only covers internal requests, the programmer is held off by
   // the external access bit instead
   assign glob_ext_deny = req_external & ext_protect;
   assign glob_int_deny = ~req_external & is_mod & ~wr_enable;

   // each reason can only add a refusal, none can lift another
   always @* begin
      deny = 1'b0;
      if (glob_ext_deny) begin
         deny = 1'b1;
      end
      if (glob_int_deny) begin
         deny = 1'b1;
      end
      if (is_mod && seg_hit) begin
         deny = 1'b1;
      end
      // nothing passes before the config word is in, or for an unknown op
      if (!loaded || is_bad) begin
         deny = 1'b1;
      end
   end

   // ----------------------------------------
   // request answer
   // ----------------------------------------
   // grant mirrors the request one cycle later, ok only when nothing refuses it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grant_valid <= 1'b0;
         grant_ok    <= 1'b0;
         grant_op    <= `PMWG_OP_READ;
         grant_addr  <= {`PMWG_ADDR_W{1'b0}};
      end else begin
         grant_valid <= req_valid;
         grant_ok    <= req_valid & ~deny;
         grant_op    <= req_op;
         grant_addr  <= req_addr;
      end
   end

   // ----------------------------------------
   // request status
   // ----------------------------------------
   reg                           stat_done;
   reg                           stat_rej;
   reg                           next_stat_done;
   reg                           next_stat_rej;
   wire                          ctrl_clear;

   // a request in the same cycle as a clear wins, so no outcome is lost
   always @* begin
      next_stat_done = stat_done;
      next_stat_rej  = stat_rej;
      if (req_valid) begin
         next_stat_done = 1'b1;
         next_stat_rej  = deny;
      end else if (ctrl_clear) begin
         next_stat_done = 1'b0;
         next_stat_rej  = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_done <= 1'b0;
         stat_rej  <= 1'b0;
      end else begin
         stat_done <= next_stat_done;
         stat_rej  <= next_stat_rej;
      end
   end

   // ----------------------------------------
   // upset handling
   // ----------------------------------------
   reg                           next_parity_error;

   // parity error stays until reset, the reset request follows the mismatch
   always @* begin
      next_parity_error = parity_error | cfg_bad;
   end

   // a live bit upset also moves the protection it controls, so do not wait
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         parity_error <= 1'b0;
         device_reset <= 1'b0;
      end else begin
         parity_error <= next_parity_error;
         device_reset <= cfg_bad;
      end
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   wire                          apb_setup;
   wire                          apb_access;
   wire                          wr_bad;
   reg                           sel_ctrl;
   reg                           sel_stat;
   reg                           sel_cfg;
   reg                           sel_none;
   reg  [31:0]                   rd_word;
   reg                           bad_acc;

   assign apb_setup  = psel & ~penable;
   assign apb_access = psel & penable & pready;
   assign wr_bad     = pwrite & ~sel_ctrl;

   // only the control word takes writes; it acts on the access edge
   assign ctrl_clear = apb_access & pwrite & sel_ctrl & pwdata[0];

   // addresses are full byte offsets, anything unmapped is an error
   always @* begin
      sel_ctrl = 1'b0;
      sel_stat = 1'b0;
      sel_cfg  = 1'b0;
      sel_none = 1'b0;
      if (paddr == `PMWG_OFS_CTRL) begin
         sel_ctrl = 1'b1;
      end else if (paddr == `PMWG_OFS_STAT) begin
         sel_stat = 1'b1;
      end else if (paddr == `PMWG_OFS_CFG) begin
         sel_cfg = 1'b1;
      end else begin
         sel_none = 1'b1;
      end
   end

   always @* begin
      rd_word = 32'h0000_0000;
      if (sel_stat) begin
         rd_word = {28'h000_0000, loaded, parity_error, stat_rej, stat_done};
      end else if (sel_cfg) begin
         rd_word = {19'h0_0000, cfg};
      end
      bad_acc = sel_none | wr_bad;
   end

   // answer one cycle after setup, data and error stand with pready
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apb_setup;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (apb_setup) begin
            pslverr <= bad_acc;
            if (!pwrite) begin
               prdata <= rd_word;
            end
         end
      end
   end
endmodule // pmwg_guard

// file: pmwg_guard_monitor.sv
// Purpose: port checker for pmwg_guard
// Assumes: grant one cycle after request
// Notes:   bound after the module
`timescale 1ns/1ps
`include "pmwg_map.vh"
module pmwg_mon (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic [12:0] cfg_flip,
   input wire logic        req_valid,
   input wire logic [1:0]  req_op,
   input wire logic [16:0] req_addr,
   input wire logic        grant_valid,
   input wire logic        grant_ok,
   input wire logic [1:0]  grant_op,
   input wire logic [16:0] grant_addr,
   input wire logic        parity_error,
   input wire logic        device_reset
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_grant_follows: assert property (req_valid |=> grant_valid) else $error("no grant");
   a_grant_cause: assert property (grant_valid |-> $past(req_valid)) else $error("stray grant");
   a_grant_addr: assert property (req_valid |=> grant_addr == $past(req_addr)) else $error("addr");
   a_grant_op: assert property (req_valid |=> grant_op == $past(req_op)) else $error("op");
   a_bad_op: assert property (req_valid && req_op == 2'h3 |=> !grant_ok) else $error("bad op");
   a_apb_answer: assert property (psel && !penable |=> pready) else $error("no pready");
   a_pready_one: assert property (pready |=> !pready) else $error("long pready");
   a_perr_sticky: assert property (parity_error |=> parity_error) else $error("perr lost");
   a_upset_reset: assert property (cfg_flip != 0 |-> ##[1:3] device_reset) else $error("no reset");
   c_deny: cover property (grant_valid && !grant_ok);
   c_allow: cover property (grant_valid && grant_ok);
   c_perr: cover property (parity_error);
endmodule // pmwg_mon
bind pmwg_guard pmwg_mon u_mon (.*);

// file: pmwg_req_model.sv
// Purpose: requester model issuing one-cycle memory requests
// Assumes: cmd is {op, addr, external}
// Notes:   idle address lines toggle so stale values never match
`timescale 1ns/1ps
module pmwg_req_model (
   input  wire logic        pclk,
   input  wire logic        go,
   input  wire logic [19:0] cmd,
   input  wire logic        grant_valid,
   input  wire logic        grant_ok,
   output logic             req_valid = 1'b0,
   output logic [1:0]       req_op = 2'h0,
   output logic [16:0]      req_addr = 17'h00000,
   output logic             req_external = 1'b0,
   output logic             last_ok = 1'b0
);
   always @(posedge pclk) begin
      req_valid <= go;
      if (go) {req_op, req_addr, req_external} <= cmd;
      else req_addr <= ~req_addr;
      if (grant_valid) last_ok <= grant_ok;
   end
endmodule // pmwg_req_model

// file: pmwg_guard_tb_top.sv
// Purpose: self-checking bench for pmwg_guard
// Assumes: grant and pready one cycle after request
// Notes:   each table row reboots with its own config word
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module pmwg_guard_tb_top;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        go = 0, cfg_valid = 0, last_ok, er, pready, pslverr;
   logic        grant_valid, grant_ok, parity_error, device_reset, req_valid, req_external;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [1:0]  req_op, grant_op;
   logic [16:0] req_addr, grant_addr;
   logic [12:0] cfg_word = 0, cfg_flip = 0;
   logic [19:0] cmd = 0;
   int          error_cnt = 0, check_count = 0;
   // cfg, op, addr, {external, allowed}
   logic [33:0] rows [15] = '{
      {13'h1FFF, 2'h1, 17'h00000, 2'b01},
      {13'h1FFD, 2'h1, 17'h00000, 2'b00},
      {13'h1FFD, 2'h1, 17'h00000, 2'b11},
      {13'h1FFE, 2'h0, 17'h1FE00, 2'b10},
      {13'h1FFE, 2'h0, 17'h1FE00, 2'b01},
      {13'h0213, 2'h1, 17'h021FF, 2'b00},
      {13'h0213, 2'h2, 17'h02200, 2'b01},
      {13'h0213, 2'h1, 17'h1FE00, 2'b01},
      {13'h0203, 2'h2, 17'h1FE00, 2'b00},
      {13'h021B, 2'h1, 17'h01FFF, 2'b01},
      {13'h021B, 2'h2, 17'h1FFFF, 2'b10},
      {13'h0217, 2'h1, 17'h02000, 2'b01},
      {13'h0211, 2'h1, 17'h03000, 2'b00},
      {13'h0213, 2'h3, 17'h08000, 2'b00},
      {13'h0213, 2'h0, 17'h00000, 2'b01}};
   pmwg_guard uut (.*);
   pmwg_req_model u_req (.*);
   initial forever #12.5 pclk = ~pclk;
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk) begin psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; end
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (!pready);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic req(input logic [19:0] c);
      @(posedge pclk) begin go <= 1; cmd <= c; end
      @(posedge pclk) go <= 0;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic boot(input logic [12:0] c);
      @(posedge pclk) presetn <= 0;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk) begin cfg_word <= c; cfg_valid <= 1; end
      @(posedge pclk) cfg_valid <= 0;
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100us;
      error_cnt++;
      finish_test;
   end
   initial begin
      for (int i = 0; i < 15; i++) begin
         boot(rows[i][33:21]);
         req(rows[i][20:1]);
         `CHK(last_ok, rows[i][0])
         $display("row %0d done", i);
      end
      boot(13'h0213);
      apb(0, 12'h008, 0);
      `CHK(rd[12:0], 13'h0213)
      @(posedge pclk) begin cfg_word <= 13'h1FFF; cfg_valid <= 1; end
      @(posedge pclk) cfg_valid <= 0;
      req({2'h1, 17'h021FF, 1'b0});
      `CHK(last_ok, 1'b0)
      apb(0, 12'h004, 0);
      `CHK(rd[3:0], 4'hB)
      apb(1, 12'h000, 32'h00000001);
      apb(0, 12'h004, 0);
      `CHK(rd[3:0], 4'h8)
      apb(1, 12'h004, 0);
      `CHK(er, 1'b1)
      apb(0, 12'h00C, 0);
      `CHK(er, 1'b1)
      $display("register test done");
      @(posedge pclk) cfg_flip <= 13'h0010;
      @(posedge pclk) cfg_flip <= 13'h0000;
      repeat (3) @(posedge pclk);
      `CHK({parity_error, device_reset}, 2'b11)
      $display("upset test done");
      finish_test;
   end
endmodule // pmwg_guard_tb_top
